/* hdl/buck3_cfg_pkg.sv */
/*
 * Constants and carrier types for the third buck converter configuration
 * register pair: offsets, field positions, reset values and signal bundles.
 * Assumes the serial control interface decodes its frames into the plain
 * register request bundle declared here.
 */
package buck3_cfg_pkg;

    // ==========================================================================
    // Register offsets
    localparam logic [7:0] RAMP_CONFIG_ADDR  = 8'h12;
    localparam logic [7:0] CLOCK_CONFIG_ADDR = 8'h13;

    // ==========================================================================
    // Field positions in the ramp configuration register
    localparam int OVP_BIT       = 7;
    localparam int FAST_DOWN_BIT = 6;
    localparam int DOWN_RAMP_BIT = 5;
    localparam int UP_RAMP_BIT   = 4;
    localparam int FAST_ON_BIT   = 3;
    localparam int SLOW_OFF_BIT  = 2;
    localparam int THRESH_LSB    = 0;

    // Field positions in the clock configuration register
    localparam int DEVIATION_BIT = 2;
    localparam int SPREAD_BIT    = 1;
    localparam int OSC_SRC_BIT   = 0;

    // ==========================================================================
    // Values after power-on reset
    localparam logic [7:0] RAMP_CONFIG_RESET  = 8'h03;
    localparam logic [7:0] CLOCK_CONFIG_RESET = 8'h05;

    // Bits writable in every part, bits writable only in engineering use, the threshold field and the readable clock bits
    localparam logic [7:0] RAMP_USER_MASK  = 8'h30;
    localparam logic [7:0] RAMP_ENG_MASK   = 8'h4f;
    localparam logic [7:0] RAMP_THR_MASK   = 8'h03;
    localparam logic [7:0] CLOCK_ENG_MASK  = 8'h07;
    localparam logic [7:0] CLOCK_READ_MASK = 8'h07;

    // ==========================================================================
    // Ramp-up threshold codes
    typedef enum logic [1:0] {
        THRESH_MINUS_50MV  = 2'h0,
        THRESH_MINUS_100MV = 2'h1,
        THRESH_MINUS_150MV = 2'h2,
        THRESH_MINUS_200MV = 2'h3
    } ramp_threshold_e;

    // Register request from the serial control interface
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    // Controls toward the analog converter
    typedef struct packed {
        logic            up_ramp_active;
        logic            down_ramp_active;
        logic            bypass_inhibit;
        logic            fast_down_ramp_en;
        logic            fast_on_high_side_en;
        logic            slow_off_high_side_en;
        ramp_threshold_e ramp_threshold_sel;
        logic            spread_deviation_sel;
        logic            spread_spectrum_en;
        logic            oscillator_source_sel;
    } converter_ctrl_s;

endpackage

/* hdl/level_sync.sv */
/*
 * Two flip-flop synchroniser for a group of slow level inputs.
 * Assumes each input is a level that holds for several clock cycles.
 */
`timescale 1ns/100ps

module level_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    // First stage feeds only the second stage
    logic [1:0][WIDTH-1:0] stage_reg;
    logic [1:0][WIDTH-1:0] stage_next;

    // Shift the inputs through both stages
    always_comb begin
        stage_next[0] = async_in;
        stage_next[1] = stage_reg[0];
    end

    // Stage registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stage_reg <= '0;
        end else begin
            stage_reg <= stage_next;
        end
    end

    assign sync_out = stage_reg[1];

endmodule

/* hdl/buck3_config_registers.sv */
/*
 * Configuration register pair of the third step-down converter, with the
 * overvoltage flag, ramp support enables, drive options, threshold select
 * and spread-spectrum clock controls, plus registered converter controls.
 * Assumes the serial control interface delivers one-cycle read and write
 * strobes on clk, and that the overvoltage comparator and the engineering
 * mode strap arrive asynchronously.
 * The controls drive the analog converter directly, so each one leaves a
 * flip-flop and none glitches while a register is written.
 * A read and a write to one register in the same cycle return the old value
 * and store the new one.
 * Limitation: the down-ramp advice for tracking mode is left to software;
 * nothing here knows whether the converter tracks.
 */
//
// What this block does
// RULE1: Overvoltage disables ramp support and bypass, sticky.
// RULE2: Software keeps down-ramp off outside tracking mode.
// RULE3: Two-bit threshold code selects -50 to -200 mV.
// RULE4: Engineering-writable bits read-only in production.
// RULE5: Power-on reset loads documented defaults.
// RULE6: Deviation select: 0 gives 200, 1 300 kHz.
// RULE7: Oscillator source: 0 own, 1 charge pump.
// RULE8: Enables active high; reserved bits read zero.
`timescale 1ns/100ps

module buck3_config_registers #(
    parameter bit THRESHOLD_PRESENT = 1'b1
) (
    input  wire logic                            clk,
    input  wire logic                            rstn,
    input  wire buck3_cfg_pkg::reg_req_s         req,
    input  wire logic                            ovp_detect,
    input  wire logic                            eng_mode,
    output logic                     [7:0]       reg_rdata,
    output logic                                 reg_rvalid,
    output buck3_cfg_pkg::converter_ctrl_s       ctrl
);

    // ==========================================================================
    // State
    typedef struct packed {
        logic [7:0]                     ramp_cfg;
        logic [7:0]                     clock_cfg;
        logic [7:0]                     rdata;
        logic                           rvalid;
        buck3_cfg_pkg::converter_ctrl_s ctrl;
    } state_s;

    state_s     state_reg;
    state_s     state_next;
    logic [1:0] sync_level;
    logic       ovp_seen;
    logic       eng_ok;

    // ==========================================================================
    // Pin synchronisation
    level_sync #(
        .WIDTH (2)
    ) u_sync (
        .clk      (clk),
        .rstn     (rstn),
        .async_in ({eng_mode, ovp_detect}),
        .sync_out (sync_level)
    );

    assign ovp_seen = sync_level[0];
    assign eng_ok   = sync_level[1];

    // ==========================================================================
    // Register update, read path and converter controls
    always_comb begin
        logic [7:0] ramp_mask;
        logic [7:0] clock_mask;
        logic       wr_ramp;
        logic       wr_clock;
        logic       ovp_clear;
        logic       ovp;
        ramp_mask  = buck3_cfg_pkg::RAMP_USER_MASK;
        clock_mask = 8'h00;
        wr_ramp    = req.wr && (req.addr == buck3_cfg_pkg::RAMP_CONFIG_ADDR);
        wr_clock   = req.wr && (req.addr == buck3_cfg_pkg::CLOCK_CONFIG_ADDR);
        ovp_clear  = wr_ramp && req.wdata[buck3_cfg_pkg::OVP_BIT];
        ovp        = 1'b0;
        state_next = state_reg;

        // Engineering bits only take writes in engineering use
        if (eng_ok) begin                                           // RULE4
            ramp_mask  = ramp_mask | buck3_cfg_pkg::RAMP_ENG_MASK;  // RULE4
            clock_mask = buck3_cfg_pkg::CLOCK_ENG_MASK;             // RULE4
        end
        // Threshold field is fixed on silicon without it
        if (!THRESHOLD_PRESENT) begin                               // RULE3
            ramp_mask = ramp_mask & ~buck3_cfg_pkg::RAMP_THR_MASK;
        end

        // Masked writes keep unwritable bits; the masks never hold the flag
        // bit, which has its own clear and set below
        if (wr_ramp) begin
            state_next.ramp_cfg = (state_reg.ramp_cfg & ~ramp_mask)
                                | (req.wdata & ramp_mask);
        end
        if (wr_clock) begin
            state_next.clock_cfg = (state_reg.clock_cfg & ~clock_mask)
                                 | (req.wdata & clock_mask);         // RULE4
        end

        // Writing one clears the flag; writing zero leaves it as it was
        if (ovp_clear) begin
            state_next.ramp_cfg[buck3_cfg_pkg::OVP_BIT] = 1'b0;     // RULE1
        end

        // Overvoltage sets the flag and wins over a clear in the same cycle,
        // so a fault still present can never be written away
        if (ovp_seen) begin
            state_next.ramp_cfg[buck3_cfg_pkg::OVP_BIT] = 1'b1;     // RULE1
        end

        // Read data one cycle after the strobe; unmapped reads return zero
        state_next.rvalid = req.rd;
        if (req.rd) begin
            unique case (req.addr)
                buck3_cfg_pkg::RAMP_CONFIG_ADDR: begin
                    state_next.rdata = state_reg.ramp_cfg;
                end
                buck3_cfg_pkg::CLOCK_CONFIG_ADDR: begin
                    state_next.rdata = state_reg.clock_cfg
                                     & buck3_cfg_pkg::CLOCK_READ_MASK; // RULE8
                end
                default: begin
                    state_next.rdata = 8'h00;
                end
            endcase
        end

        // Converter controls follow the updated register values, so they
        // move on the same edge as the write that changes them.
        // The flag forces bypass and both ramp supports off whatever the
        // enable bits hold; the bits themselves are kept for after the clear.
        ovp = state_next.ramp_cfg[buck3_cfg_pkg::OVP_BIT];
        state_next.ctrl.bypass_inhibit   = ovp;                     // RULE1
        state_next.ctrl.up_ramp_active   =
            state_next.ramp_cfg[buck3_cfg_pkg::UP_RAMP_BIT] && !ovp;     // RULE1
        state_next.ctrl.down_ramp_active =
            state_next.ramp_cfg[buck3_cfg_pkg::DOWN_RAMP_BIT] && !ovp;   // RULE1
        // Drive options and ramp speed pass straight through
        state_next.ctrl.fast_down_ramp_en =
            state_next.ramp_cfg[buck3_cfg_pkg::FAST_DOWN_BIT];            // RULE8
        state_next.ctrl.fast_on_high_side_en =
            state_next.ramp_cfg[buck3_cfg_pkg::FAST_ON_BIT];              // RULE8
        state_next.ctrl.slow_off_high_side_en =
            state_next.ramp_cfg[buck3_cfg_pkg::SLOW_OFF_BIT];             // RULE8
        state_next.ctrl.ramp_threshold_sel = buck3_cfg_pkg::ramp_threshold_e'(
            state_next.ramp_cfg[buck3_cfg_pkg::THRESH_LSB +: 2]);         // RULE3
        // Spread-spectrum clock controls from the second register
        state_next.ctrl.spread_deviation_sel =
            state_next.clock_cfg[buck3_cfg_pkg::DEVIATION_BIT];           // RULE6
        state_next.ctrl.spread_spectrum_en =
            state_next.clock_cfg[buck3_cfg_pkg::SPREAD_BIT];              // RULE8
        state_next.ctrl.oscillator_source_sel =
            state_next.clock_cfg[buck3_cfg_pkg::OSC_SRC_BIT];             // RULE7
    end

    // State register with power-on defaults
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg                            <= '0;
            state_reg.ramp_cfg                   <= buck3_cfg_pkg::RAMP_CONFIG_RESET;  // RULE5
            state_reg.clock_cfg                  <= buck3_cfg_pkg::CLOCK_CONFIG_RESET; // RULE5
            state_reg.ctrl.ramp_threshold_sel    <= buck3_cfg_pkg::THRESH_MINUS_200MV; // RULE5
            state_reg.ctrl.spread_deviation_sel  <= 1'b1;                              // RULE6
            state_reg.ctrl.oscillator_source_sel <= 1'b1;                              // RULE7
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from the state register
    assign reg_rdata  = state_reg.rdata;
    assign reg_rvalid = state_reg.rvalid;
    assign ctrl       = state_reg.ctrl;

endmodule

/* verification/buck3_cfg_properties.sv */
/* Concurrent checks on the ports of the buck3 configuration registers.
   Assumes it is bound to that module and sees only its ports. */
`timescale 1ns/100ps
module buck3_cfg_properties #(
    parameter bit THRESHOLD_PRESENT = 1'b1
) (
    input wire logic                            clk,
    input wire logic                            rstn,
    input wire buck3_cfg_pkg::reg_req_s         req,
    input wire logic                            ovp_detect,
    input wire logic                            eng_mode,
    input wire logic                     [7:0]  reg_rdata,
    input wire logic                            reg_rvalid,
    input wire buck3_cfg_pkg::converter_ctrl_s  ctrl
);
    // ==========================================================================
    // Overvoltage, write protection, read path
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    ovp_block_a: assert property (ctrl.bypass_inhibit |-> !ctrl.up_ramp_active &&
        !ctrl.down_ramp_active) else $error("ramp active in overvoltage");
    ovp_set_a: assert property (ovp_detect [*3] |=> ctrl.bypass_inhibit)
        else $error("overvoltage flag not set");
    ovp_sticky_a: assert property (ctrl.bypass_inhibit && !(req.wr && req.wdata[7])
        |=> ctrl.bypass_inhibit) else $error("overvoltage flag dropped");
    ramp_ro_a: assert property (!eng_mode [*3] ##0 req.wr |=>
        $stable({ctrl.fast_down_ramp_en, ctrl.fast_on_high_side_en,
        ctrl.slow_off_high_side_en, ctrl.ramp_threshold_sel}))
        else $error("protected ramp field changed");
    clock_ro_a: assert property (!eng_mode [*3] ##0 req.wr |=>
        $stable({ctrl.spread_spectrum_en, ctrl.spread_deviation_sel,
        ctrl.oscillator_source_sel})) else $error("clock field changed");
    ramp_en_a: assert property (req.wr && req.addr == buck3_cfg_pkg::RAMP_CONFIG_ADDR ##1
        !ctrl.bypass_inhibit |-> ctrl.up_ramp_active == $past(req.wdata[4]) &&
        ctrl.down_ramp_active == $past(req.wdata[5])) else $error("ramp enable wrong");
    rsvd_read_a: assert property (req.rd && req.addr == buck3_cfg_pkg::CLOCK_CONFIG_ADDR
        |=> reg_rvalid && reg_rdata[7:3] == 5'h00) else $error("reserved bits not zero");
    clock_map_a: assert property (req.rd && !req.wr && req.addr == 8'h13 |=>
        reg_rdata[2:0] == {ctrl.spread_deviation_sel, ctrl.spread_spectrum_en,
        ctrl.oscillator_source_sel}) else $error("clock controls differ from register");
    unmapped_read_a: assert property (req.rd && req.addr[7:1] != 7'h09 |=> reg_rvalid &&
        reg_rdata == 8'h00) else $error("unmapped read not zero");
endmodule
bind buck3_config_registers buck3_cfg_properties #(.THRESHOLD_PRESENT(THRESHOLD_PRESENT)) i_props (
    .clk(clk), .rstn(rstn), .req(req), .ovp_detect(ovp_detect), .eng_mode(eng_mode),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .ctrl(ctrl));

/* verification/buck3_config_registers_tb_top.sv */
/* Directed testbench for the buck3 configuration registers.
   Assumes the checker file is compiled alongside for its bind. */
`timescale 1ns/100ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; \
    $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module buck3_config_registers_tb_top;
    logic                           clk = 1'b0;
    logic                           rstn = 1'b0;
    buck3_cfg_pkg::reg_req_s        req = '0;
    logic                           ovp_detect = 1'b0;
    logic                           eng_mode = 1'b0;
    logic [7:0]                     reg_rdata;
    logic                           reg_rvalid;
    buck3_cfg_pkg::converter_ctrl_s ctrl;
    int                             n_mismatch = 0;
    int                             n_compared = 0;
    int                             cycles = 0;

    // ==========================================================================
    // Clock, design and hang guard
    always #12.5 clk = ~clk;
    buck3_config_registers i_dut (.clk(clk), .rstn(rstn), .req(req), .ovp_detect(ovp_detect),
        .eng_mode(eng_mode), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .ctrl(ctrl));
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            finish_test();
        end
    end

    // ==========================================================================
    // Register access tasks, driven on the falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(negedge clk);
        req.wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        req.rd = 1'b1;
        req.addr = a;
        @(negedge clk);
        req.rd = 1'b0;
        `CHK(reg_rvalid, 1'b1)
        `CHK(reg_rdata, e)
    endtask
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ==========================================================================
    // Main sequence
    initial begin
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        rd(8'h12, 8'h03);
        rd(8'h13, 8'h05);
        `CHK(ctrl.oscillator_source_sel, 1'b1)
        `CHK(ctrl.spread_deviation_sel, 1'b1)
        wr(8'h12, 8'hff);
        rd(8'h12, 8'h33);
        `CHK(ctrl.down_ramp_active, 1'b1)
        wr(8'h13, 8'hff);
        rd(8'h13, 8'h05);
        wr(8'h14, 8'hff);
        rd(8'h14, 8'h00);
        // Engineering use opens the protected fields
        eng_mode = 1'b1;
        repeat (3) @(negedge clk);
        for (int i = 0; i < 4; i++) begin
            wr(8'h12, 8'(i));
            rd(8'h12, 8'(i));
            `CHK(ctrl.ramp_threshold_sel, 2'(i))
        end
        wr(8'h12, 8'h4c);
        rd(8'h12, 8'h4c);
        `CHK({ctrl.fast_down_ramp_en, ctrl.fast_on_high_side_en}, 2'h3)
        `CHK(ctrl.slow_off_high_side_en, 1'b1)
        for (int i = 0; i < 8; i++) begin
            wr(8'h13, 8'(i));
            rd(8'h13, 8'(i));
            `CHK(ctrl.spread_deviation_sel, i[2])
            `CHK(ctrl.spread_spectrum_en, i[1])
            `CHK(ctrl.oscillator_source_sel, i[0])
        end
        // Overvoltage forces ramp support off until cleared
        wr(8'h12, 8'h30);
        ovp_detect = 1'b1;
        repeat (4) @(negedge clk);
        rd(8'h12, 8'hb0);
        `CHK({ctrl.bypass_inhibit, ctrl.up_ramp_active}, 2'h2)
        wr(8'h12, 8'hb0);
        rd(8'h12, 8'hb0);
        ovp_detect = 1'b0;
        repeat (4) @(negedge clk);
        rd(8'h12, 8'hb0);
        // Clear the flag while keeping both ramp supports set
        wr(8'h12, 8'hb0);
        rd(8'h12, 8'h30);
        `CHK(ctrl.up_ramp_active, 1'b1)
        // Outside tracking mode software leaves the down-ramp support off
        wr(8'h12, 8'h10);
        `CHK({ctrl.up_ramp_active, ctrl.down_ramp_active}, 2'h2)
        finish_test();
    end
endmodule
